// [hw/adcc_ctrl.sv]
// Conversion sequencing and serial slave port of a delta-sigma converter.
// Assumes the analog core delivers codes on the system clock and that the
// host clocks the serial port from its own, unrelated clock.
`timescale 1ns/1ps
`default_nettype none

module adcc_ctrl
   import adcc_pkg::*;
#(
   parameter int unsigned P_TO_TICKS  = LP_TO_TICKS,
   parameter int unsigned P_CONV_DIV  = 1
) (
   // System clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_resetn,
   // Serial port pins
   input  wire logic        i_sclk,
   input  wire logic        i_cs_n,
   input  wire logic        i_din,
   output logic             o_dout,
   output logic             o_dout_oe,
   // Analog core
   input  wire logic [15:0] i_adc_code,
   input  wire logic [13:0] i_temp_code,
   output logic             o_core_on,
   output logic             o_conv_start,
   output var adcc_cfg_t    o_cfg
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]          tick_cnt;
   logic                tick;
   logic                cs_m1, cs_m2, cs_m3;
   logic                sk_m1, sk_m2, sk_m3;
   logic                dq_m1, dq_m2;
   logic                sn_m1, sn_m2;
   logic                ct_m1, ct_m2, ct_m3;
   logic                st_m1, st_m2, st_m3;
   logic                dt_m1, dt_m2, dt_m3;
   logic                cfg_evt, start_evt, done_evt;
   logic [LP_TO_W-1:0]  to_cnt;
   logic                to_flag;
   logic                ser_rst;
   logic [5:0]          bit_cnt;
   logic [14:0]         din_sr;
   adcc_cfg_t           cfg_word;
   logic                wrote;
   logic                cfg_tog, start_tog, done_tog;
   logic                dq, seen;
   logic [15:0]         hold_conv;
   logic [15:0]         hold_cfg;
   logic [15:0]         conv_reg;
   logic                new_data;
   adcc_state_t         state, next_state;
   logic [16:0]         conv_cnt;
   logic                conv_done;
   logic                cfg_ok;
   logic                go_single, go_cont;
   logic [16:0]         load_ticks;

   ////////////////////////////////////////////////////////////////////////
   // 1 MHz timebase
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt <= 8'h00;
         tick     <= 1'b0;
      end else begin
         tick     <= (tick_cnt == LP_TICK_LAST);
         tick_cnt <= (tick_cnt == LP_TICK_LAST) ? 8'h00 : tick_cnt + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers into the system clock
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         {cs_m1, cs_m2, cs_m3} <= 3'h7;
         {sk_m1, sk_m2, sk_m3} <= 3'h0;
         {dq_m1, dq_m2}        <= 2'h0;
         {sn_m1, sn_m2}        <= 2'h0;
         {ct_m1, ct_m2, ct_m3} <= 3'h0;
         {st_m1, st_m2, st_m3} <= 3'h0;
         {dt_m1, dt_m2, dt_m3} <= 3'h0;
      end else begin
         {cs_m1, cs_m2, cs_m3} <= {i_cs_n, cs_m1, cs_m2};
         {sk_m1, sk_m2, sk_m3} <= {i_sclk, sk_m1, sk_m2};
         {dq_m1, dq_m2}        <= {dq, dq_m1};
         {sn_m1, sn_m2}        <= {seen, sn_m1};
         {ct_m1, ct_m2, ct_m3} <= {cfg_tog, ct_m1, ct_m2};
         {st_m1, st_m2, st_m3} <= {start_tog, st_m1, st_m2};
         {dt_m1, dt_m2, dt_m3} <= {done_tog, dt_m1, dt_m2};
      end
   end

   assign cfg_evt   = ct_m2 ^ ct_m3;
   assign start_evt = st_m2 ^ st_m3;
   assign done_evt  = dt_m2 ^ dt_m3;

   ////////////////////////////////////////////////////////////////////////
   // Serial clock low time-out
   // Cleared as soon as the clock is seen high, well inside the first half
   // period, so the first falling edge after it already counts.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         to_cnt  <= '0;
         to_flag <= 1'b0;
      end else begin
         if (cs_m2 || sk_m2 || (sk_m2 != sk_m3) || (cs_m2 != cs_m3)) begin
            to_cnt <= '0;
         end else if (tick && !to_flag) begin
            to_cnt <= to_cnt + LP_TO_W'(1);
         end
         if (cs_m2 || sk_m2) begin
            to_flag <= 1'b0;
         end else if (tick && to_cnt == LP_TO_W'(P_TO_TICKS - 1)) begin
            to_flag <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link side: falling edge takes data in
   assign ser_rst = i_cs_n | to_flag;

   always_ff @(negedge i_sclk or posedge ser_rst) begin
      if (ser_rst) begin
         bit_cnt <= LP_BIT_FIRST;
         din_sr  <= '0;
         wrote   <= 1'b0;
      end else begin
         din_sr  <= {din_sr[13:0], i_din};
         bit_cnt <= (bit_cnt == LP_BIT_LAST) ? LP_BIT_FIRST
                                             : bit_cnt + 6'h01;
         if (bit_cnt == LP_BIT_HALF) begin
            wrote <= (din_sr[1:0] == LP_NOP_VALID);
         end else if (bit_cnt == LP_BIT_LAST) begin
            wrote <= 1'b0;
         end
      end
   end

   // Toggles and the received word survive the port reset so that an
   // event already on its way to the system side is not lost.
   always_ff @(negedge i_sclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_word  <= adcc_cfg_t'(LP_CFG_RESET);
         cfg_tog   <= 1'b0;
         start_tog <= 1'b0;
         done_tog  <= 1'b0;
      end else if (!ser_rst) begin
         if (bit_cnt == LP_BIT_HALF) begin
            cfg_word <= adcc_cfg_t'({din_sr, i_din});
            cfg_tog  <= ~cfg_tog;
         end
         if (bit_cnt == LP_BIT_FIRST) begin
            start_tog <= ~start_tog;
         end
         if (bit_cnt == LP_BIT_LAST) begin
            done_tog <= ~done_tog;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link side: rising edge sends data out
   // The hold words are frozen by the system side for the whole transfer.
   always_ff @(posedge i_sclk or posedge i_cs_n) begin
      if (i_cs_n) begin
         dq   <= 1'b1;
         seen <= 1'b0;
      end else begin
         seen <= 1'b1;
         if (bit_cnt[4] == 1'b0) begin
            dq <= adcc_pick(hold_conv, bit_cnt[3:0]);
         end else begin
            dq <= adcc_pick(wrote ? 16'(cfg_word) : hold_cfg,
                            bit_cnt[3:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer capture and ready flag
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         hold_conv <= LP_CONV_RESET;
         hold_cfg  <= LP_CFG_RESET;
      end else if (cs_m2 || to_flag || done_evt) begin
         hold_conv <= conv_reg;
         hold_cfg  <= {state != ADCC_CONVERT, 15'(o_cfg)};
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         new_data <= 1'b0;
      end else if (conv_done) begin
         new_data <= 1'b1;
      end else if (start_evt) begin
         new_data <= 1'b0;
      end
   end

   // Before the first rising edge the pin carries the ready level.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dout    <= 1'b1;
         o_dout_oe <= 1'b0;
      end else begin
         o_dout_oe <= ~cs_m2;
         o_dout    <= sn_m2 ? dq_m2 : ~new_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration
   // A frame whose command field is not the valid pattern leaves it alone.
   assign cfg_ok    = cfg_evt && (cfg_word.nop == LP_NOP_VALID);
   assign go_single = cfg_ok && cfg_word.ss && !cfg_word.mode
                      ? 1'b0 : cfg_ok && cfg_word.ss && cfg_word.mode;
   assign go_cont   = cfg_ok && (cfg_word.mode == LP_MODE_CONT);

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_cfg <= adcc_cfg_t'(LP_CFG_RESET);
      end else if (cfg_ok) begin
         o_cfg    <= cfg_word;
         o_cfg.ss <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion sequencer
   assign load_ticks = 17'(adcc_conv_ticks(cfg_ok ? cfg_word.dr : o_cfg.dr)
                           / P_CONV_DIV);
   assign conv_done  = (state == ADCC_CONVERT) && tick && (conv_cnt <= 17'h1);

   always_comb begin
      next_state = state;
      case (state)
         ADCC_PDOWN: begin
            if (go_single || go_cont) begin
               next_state = ADCC_CONVERT;
            end
         end
         ADCC_CONVERT: begin
            if (conv_done && o_cfg.mode != LP_MODE_CONT && !go_cont) begin
               next_state = ADCC_PDOWN;
            end
         end
         default: next_state = ADCC_PDOWN;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ADCC_PDOWN;
      end else begin
         state <= next_state;
      end
   end

   // A trigger during a running conversion reaches no branch here.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         conv_cnt     <= '0;
         o_conv_start <= 1'b0;
         o_core_on    <= 1'b0;
      end else begin
         o_conv_start <= 1'b0;
         o_core_on    <= (next_state == ADCC_CONVERT);
         if (state == ADCC_PDOWN && next_state == ADCC_CONVERT) begin
            conv_cnt     <= load_ticks;
            o_conv_start <= 1'b1;
         end else if (conv_done && next_state == ADCC_CONVERT) begin
            conv_cnt     <= load_ticks;
            o_conv_start <= 1'b1;
         end else if (state == ADCC_CONVERT && tick) begin
            conv_cnt <= conv_cnt - 17'h1;
         end
      end
   end

   // Temperature codes are 0.03125 C steps, already twos complement.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         conv_reg <= LP_CONV_RESET;
      end else if (conv_done) begin
         conv_reg <= o_cfg.ts ? {i_temp_code, 2'h0}
                              : i_adc_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   property p_tick_period;
      tick |-> ##250 tick;
   endproperty
   a_tick_period: assert property (p_tick_period)
      else $error("timebase tick not every 250 cycles");

   property p_temp_format;
      (conv_done && o_cfg.ts) |=>
         conv_reg == {$past(i_temp_code), 2'h0};
   endproperty
   a_temp_format: assert property (p_temp_format)
      else $error("temperature result not left-justified");

   property p_adc_select;
      (conv_done && !o_cfg.ts) |=> conv_reg == $past(i_adc_code);
   endproperty
   a_adc_select: assert property (p_adc_select)
      else $error("wrong source stored in result");

   property p_single_start;
      (state == ADCC_PDOWN && go_single) |=>
         state == ADCC_CONVERT && o_conv_start && o_core_on && !o_cfg.ss;
   endproperty
   a_single_start: assert property (p_single_start)
      else $error("single-shot trigger did not start conversion");

   property p_busy_ignore;
      (state == ADCC_CONVERT && go_single && !tick) |=>
         !o_conv_start && conv_cnt == $past(conv_cnt);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("trigger restarted a running conversion");

   property p_cont_restart;
      (conv_done && o_cfg.mode == LP_MODE_CONT) |=>
         state == ADCC_CONVERT && o_conv_start ##1 !o_conv_start;
   endproperty
   a_cont_restart: assert property (p_cont_restart)
      else $error("continuous mode did not restart");

   property p_single_down;
      (conv_done && o_cfg.mode != LP_MODE_CONT && !go_cont) |=>
         state == ADCC_PDOWN && !o_core_on;
   endproperty
   a_single_down: assert property (p_single_down)
      else $error("single-shot did not power down");

   property p_oe_follows_cs;
      (cs_m2 != cs_m3) |=> o_dout_oe == !$past(cs_m2);
   endproperty
   a_oe_follows_cs: assert property (p_oe_follows_cs)
      else $error("data pin enable does not follow chip select");

   property p_ready_shown;
      (!cs_m2 && !sn_m2 && new_data && !start_evt) |=> !o_dout;
   endproperty
   a_ready_shown: assert property (p_ready_shown)
      else $error("ready level not shown after chip select fall");

   property p_to_release;
      (to_flag && sk_m2) |=> !to_flag;
   endproperty
   a_to_release: assert property (p_to_release)
      else $error("time-out restart not released by clock");

   c_single: cover property (state == ADCC_PDOWN && go_single);
   c_cont:   cover property (conv_done && o_cfg.mode == LP_MODE_CONT);
   c_to:     cover property ($rose(to_flag));
   c_xfer:   cover property (done_evt && !cs_m2);

endmodule

`default_nettype wire

// [shared/adcc_pkg.sv]
// Shared constants, types and helpers for the converter control block.
// Assumes a 250 MHz system clock; the 1 MHz timebase is divided from it.
package adcc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timebase
   localparam int unsigned LP_MCLK_HZ  = 250_000_000;
   localparam int unsigned LP_OSC_HZ   = 1_000_000;
   localparam int unsigned LP_TICK_DIV = LP_MCLK_HZ / LP_OSC_HZ;
   localparam logic [7:0]  LP_TICK_LAST = 8'(LP_TICK_DIV - 1);

   // Serial clock low time-out, in ms and in 1 MHz ticks
   localparam int unsigned LP_TO_MS    = 28;
   localparam int unsigned LP_TO_TICKS = LP_TO_MS * (LP_OSC_HZ / 1000);
   localparam int unsigned LP_TO_W     = 15;

   ////////////////////////////////////////////////////////////////////////
   // Configuration word
   typedef struct packed {
      logic       ss;
      logic [2:0] mux;
      logic [2:0] pga;
      logic       mode;
      logic [2:0] dr;
      logic       ts;
      logic       pull_up;
      logic [1:0] nop;
      logic       rsv;
   } adcc_cfg_t;

   localparam logic [15:0] LP_CFG_RESET = 16'h058b;
   localparam logic [1:0]  LP_NOP_VALID = 2'h1;
   localparam logic        LP_MODE_CONT = 1'h0;
   localparam logic [15:0] LP_CONV_RESET = 16'h0000;

   // Transfer framing
   localparam logic [5:0] LP_BIT_FIRST = 6'h00;
   localparam logic [5:0] LP_BIT_HALF  = 6'h0f;
   localparam logic [5:0] LP_BIT_LAST  = 6'h1f;

   typedef enum logic {ADCC_PDOWN, ADCC_CONVERT} adcc_state_t;

   ////////////////////////////////////////////////////////////////////////
   // Conversion length in 1 MHz ticks for each data-rate code
   function automatic logic [16:0] adcc_conv_ticks(input logic [2:0] dr);
      case (dr)
         3'h0:    adcc_conv_ticks = 17'h1e848;
         3'h1:    adcc_conv_ticks = 17'h0f424;
         3'h2:    adcc_conv_ticks = 17'h07a12;
         3'h3:    adcc_conv_ticks = 17'h03d09;
         3'h4:    adcc_conv_ticks = 17'h01e84;
         3'h5:    adcc_conv_ticks = 17'h00fa0;
         3'h6:    adcc_conv_ticks = 17'h00839;
         default: adcc_conv_ticks = 17'h0048a;
      endcase
   endfunction

   // Bit of a 16-bit word sent at a given position, MSB first
   function automatic logic adcc_pick(input logic [15:0] w,
                                      input logic [3:0]  pos);
      adcc_pick = w[4'hf - pos];
   endfunction

endpackage

// [tb/adcc_host.sv]
// Host-side serial master model for the converter control block.
// Assumes the bench calls its tasks; shift runs the link clock whether or not chip select is low.
`timescale 1ns/1ps
`default_nettype none

module adcc_host (
   // Serial pins towards the converter
   output var logic  o_sclk,
   output var logic  o_cs_n,
   output var logic  o_din,
   input  wire logic i_dout,
   input  wire logic i_dout_oe
);
   logic      last_seen;
   wire logic line;

   // Released pin shows the inverse of its last level, never a stale copy
   assign line = i_dout_oe ? i_dout : ~last_seen;

   always @* begin
      if (i_dout_oe === 1'b1) begin
         last_seen = i_dout;
      end
   end

   initial begin
      last_seen = 1'b0;
      o_sclk    = 1'b0;
      o_cs_n    = 1'b1;
      o_din     = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Chip select change, then look at the pin after it has settled
   task automatic select(input logic low, output logic ready_n);
      o_cs_n = ~low;
      #40;
      ready_n = line;
   endtask

   // Half period of 40 ns gives the 80 ns link clock; idles low after
   task automatic shift(input int n, input logic [31:0] tx,
                        output logic [31:0] rx);
      rx = 32'h0;
      for (int i = 0; i < n; i++) begin
         o_sclk = 1'b1;
         o_din  = tx[31-i];
         #40;
         rx     = {rx[30:0], line};
         o_sclk = 1'b0;
         #40;
      end
   endtask
endmodule

`default_nettype wire

// [tb/adcc_ctrl_bench.sv]
// Self-checking bench for the converter control block.
// Assumes shortened time-out and conversion lengths via parameters.
`timescale 1ns/1ps
`default_nettype none

module adcc_ctrl_bench;
   import adcc_pkg::*;

   localparam int unsigned LP_SIM_TO  = 20;
   localparam int unsigned LP_SIM_DIV = 1000;

   logic        i_mclk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [15:0] adc_code = 16'h0;
   logic [13:0] temp_code = 14'h0;
   wire logic   sclk, cs_n, din, dout, dout_oe, core_on, conv_start;
   adcc_cfg_t   cfg;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n_start = 0;

   adcc_ctrl #(.P_TO_TICKS(LP_SIM_TO), .P_CONV_DIV(LP_SIM_DIV)) uut (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_din(din), .o_dout(dout), .o_dout_oe(dout_oe),
      .i_adc_code(adc_code), .i_temp_code(temp_code),
      .o_core_on(core_on), .o_conv_start(conv_start), .o_cfg(cfg));

   adcc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
                   .i_dout(dout), .i_dout_oe(dout_oe));

   always #2 i_mclk = ~i_mclk;

   always @(posedge i_mclk) begin
      if (conv_start === 1'b1) begin
         n_start++;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [15:0] mk(input logic ss, input logic mode,
                                      input logic [2:0] dr, input logic ts);
      adcc_cfg_t c;
      c      = LP_CFG_RESET;
      c.ss   = ss;
      c.mode = mode;
      c.dr   = dr;
      c.ts   = ts;
      return c;
   endfunction

   // A command field of zero makes a frame read-only
   task automatic frame(input int n, input logic [15:0] wr,
                        output logic rdy, output logic [31:0] rx);
      logic dummy;
      #1;
      host.select(1'b1, rdy);
      host.shift(n, {wr, 16'h0}, rx);
      host.select(1'b0, dummy);
      repeat (8) @(posedge i_mclk);
   endtask

   task automatic wait_off(input int lim);
      for (int i = 0; i < lim && core_on !== 1'b0; i++) begin
         @(posedge i_mclk);
      end
      #1;
   endtask

   task automatic do_reset();
      @(posedge i_mclk);
      #1 i_resetn = 1'b0;
      repeat (4) @(posedge i_mclk);
      #1 i_resetn = 1'b1;
      repeat (4) @(posedge i_mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (200) @(posedge i_mclk);
      check("cfg", cfg, 32'h058b);
      check("core_on", core_on, 0);
      check("oe", dout_oe, 0);
      check("starts", n_start, 0);
   endtask

   task automatic t_single();
      logic        r;
      logic [31:0] rx;
      #1 adc_code = 16'h8001;
      frame(16, mk(1, 1, 3'h7, 0), r, rx);
      check("start", n_start, 1);
      check("ss", cfg.ss, 0);
      wait_off(2000);
      check("core_off", core_on, 0);
      frame(16, 16'h0, r, rx);
      check("ready", r, 0);
      check("result", rx, 32'h8001);
      frame(16, 16'h0, r, rx);
      check("not_ready", r, 1);
      check("again", rx, 32'h8001);
   endtask

   task automatic t_temp();
      logic        r;
      logic [31:0] rx;
      #1 temp_code = 14'h3ce0;
      frame(16, mk(1, 1, 3'h7, 1), r, rx);
      wait_off(2000);
      frame(16, 16'h0, r, rx);
      check("temp", rx, 32'hf380);
   endtask

   task automatic t_busy();
      logic        r;
      logic [31:0] rx;
      int          n0;
      n0 = n_start;
      frame(16, mk(1, 1, 3'h0, 0), r, rx);
      frame(16, mk(1, 1, 3'h0, 0), r, rx);
      check("busy_on", core_on, 1);
      wait_off(40000);
      check("busy_starts", n_start - n0, 1);
   endtask

   task automatic t_cont();
      logic        r;
      logic [31:0] rx;
      int          n0;
      adc_code = 16'h1234;
      n0 = n_start;
      frame(16, mk(0, 0, 3'h7, 0), r, rx);
      repeat (1000) @(posedge i_mclk);
      check("cont", n_start - n0 >= 3, 1);
      fork
         frame(16, 16'h0, r, rx);
         begin
            repeat (100) @(posedge i_mclk);
            #1 adc_code = 16'hedcb;
         end
      join
      check("held", rx, 32'h1234);
      frame(16, mk(0, 1, 3'h7, 0), r, rx);
      wait_off(2000);
      n0 = n_start;
      repeat (1000) @(posedge i_mclk);
      check("stop", n_start - n0, 0);
      frame(16, mk(0, 0, 3'h7, 0), r, rx);
      do_reset();
      n0 = n_start;
      repeat (1000) @(posedge i_mclk);
      check("rst_stop", n_start - n0, 0);
      check("rst_cfg", cfg, 32'h058b);
   endtask

   task automatic t_port();
      logic        r;
      logic [31:0] rx;
      frame(32, mk(0, 1, 3'h7, 0), r, rx);
      check("readback", rx[15:0], mk(0, 1, 3'h7, 0));
      frame(32, 16'h0, r, rx);
      check("status", rx[15:0], mk(1, 1, 3'h7, 0));
      #1;
      host.shift(16, {mk(0, 1, 3'h2, 0), 16'h0}, rx);
      check("cs_high", cfg, mk(0, 1, 3'h7, 0));
      host.select(1'b1, r);
      host.shift(5, 32'h0, rx);
      repeat (LP_SIM_TO * 250 + 500) @(posedge i_mclk);
      #1;
      host.shift(16, {mk(0, 1, 3'h5, 0), 16'h0}, rx);
      host.select(1'b0, r);
      repeat (8) @(posedge i_mclk);
      check("timeout", cfg, mk(0, 1, 3'h5, 0));
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #380000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge i_mclk);
      #1 i_resetn = 1'b1;
      repeat (4) @(posedge i_mclk);
      t_reset();
      t_single();
      t_temp();
      t_busy();
      t_cont();
      t_port();
      end_of_test();
   end
endmodule

`default_nettype wire
